// file: pkg/quad_load_pkg.sv
// Shared constants for the absolute-position quadrature load link
package quad_load_pkg;
  localparam int STEP_BITS = 12;
  localparam int REV_BITS  = 12;
  localparam int POS_BITS  = STEP_BITS + REV_BITS;
  localparam int DLY_BITS  = 16;
  localparam int DIV_BITS  = 16;
  // Default edge period: 1001 clocks (reload 1000 down to zero), about 99.9 kHz at 100 MHz, inside 2..115 kHz
  localparam logic [DIV_BITS-1:0] EDGE_DIV_DEFAULT = 16'h03e8;
  localparam logic [DLY_BITS-1:0] LOAD_DLY_DEFAULT = 16'h0064;
  localparam logic [1:0] PH0 = 2'h0;
  localparam logic [1:0] PH1 = 2'h1;
  localparam logic [1:0] PH2 = 2'h3;
  localparam logic [1:0] PH3 = 2'h2;
  localparam logic [POS_BITS-1:0] POS_ZERO = 24'h000000;
  localparam logic [POS_BITS-1:0] POS_ONE  = 24'h000001;
endpackage

// file: pkg/quad_load_if.sv
// Link wires between the encoder end and the controller end
interface quad_load_if;
  logic track_a;
  logic track_b;
  logic load_req;
  logic loading;
  modport encoder    (output track_a, output track_b, output loading, input load_req);
  modport controller (input track_a, input track_b, input loading, output load_req);
endinterface

// file: rtl/quad_encoder_end.sv
// Encoder end: emits position changes as quadrature and answers load requests
module quad_encoder_end #(
  parameter int POS_BITS = quad_load_pkg::POS_BITS,
  parameter int DLY_BITS = quad_load_pkg::DLY_BITS,
  parameter int DIV_BITS = quad_load_pkg::DIV_BITS
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [POS_BITS-1:0] position_i,
  input  wire logic [DLY_BITS-1:0] load_delay_i,
  input  wire logic [DIV_BITS-1:0] edge_div_i,
  output logic [POS_BITS-1:0]      reported_o,
  output logic                     busy_o,
  quad_load_if.encoder             link
);
  typedef enum logic [3:0] {
    S_TRACK    = 4'h1,
    S_HOLD     = 4'h2,
    S_DELAY    = 4'h4,
    S_REPLAY   = 4'h8
  } state_t;

  state_t                state_q, state_d;
  logic [1:0]            req_sync_q;
  logic                  req_seen_q;
  logic [DIV_BITS-1:0]   div_q;
  logic [DLY_BITS-1:0]   dly_q;
  logic [POS_BITS-1:0]   rep_q;
  logic [1:0]            phase_q;
  logic                  ta_q, tb_q, ld_q;

  // Three-stage pin sync; change taken when stages two and three agree
  logic req_meta_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 2'h0;
    end else begin
      req_meta_q <= link.load_req;
      req_sync_q <= {req_sync_q[0], req_meta_q};
    end
  end

  // A one-cycle pulse is a glitch and is ignored
  wire                req_agree = (req_sync_q[0] == req_sync_q[1]);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_seen_q <= 1'b0;
    end else if (req_agree) begin
      req_seen_q <= req_sync_q[1];
    end
  end

  wire                edge_tick = (div_q == '0);
  wire                step_up   = (position_i > rep_q);
  wire                step_dn   = (position_i < rep_q);
  wire                replaying = (state_q == S_REPLAY);
  wire                tracking  = (state_q == S_TRACK);
  // While tracking, follow the shaft; while replaying, the count climbs from zero
  wire                do_up     = edge_tick && (tracking || replaying) && step_up;
  wire                do_dn     = edge_tick && tracking && step_dn;
  wire                dly_done  = (dly_q == '0);
  wire [1:0]          phase_up  = (phase_q == quad_load_pkg::PH0) ? quad_load_pkg::PH1 :
                                  (phase_q == quad_load_pkg::PH1) ? quad_load_pkg::PH2 :
                                  (phase_q == quad_load_pkg::PH2) ? quad_load_pkg::PH3 :
                                  quad_load_pkg::PH0;
  wire [1:0]          phase_dn  = (phase_q == quad_load_pkg::PH0) ? quad_load_pkg::PH3 :
                                  (phase_q == quad_load_pkg::PH3) ? quad_load_pkg::PH2 :
                                  (phase_q == quad_load_pkg::PH2) ? quad_load_pkg::PH1 :
                                  quad_load_pkg::PH0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_TRACK:  if (req_seen_q) state_d = S_DELAY;
      S_DELAY:  if (dly_done) state_d = req_seen_q ? S_HOLD : S_REPLAY;
      S_HOLD:   if (!req_seen_q) state_d = S_DELAY;
      S_REPLAY: if (!step_up) state_d = S_TRACK;
      default:  state_d = S_TRACK;
    endcase
  end

  wire                entering_delay = (state_d == S_DELAY) && (state_q != S_DELAY);
  wire                holding        = (state_q == S_HOLD);
  wire                delaying       = (state_q == S_DELAY);
  // The count restarts at zero while the controller clears its own counter
  wire                clear_rep      = holding || (delaying && ld_q);
  wire                loading_d      = (state_d != S_TRACK);
  wire                track_a_d      = phase_q[1];
  wire                track_b_d      = phase_q[0];
  wire [DLY_BITS-1:0] dly_next       = dly_q - DLY_BITS'(1'b1);
  wire [DIV_BITS-1:0] div_next       = div_q - DIV_BITS'(1'b1);
  wire [POS_BITS-1:0] rep_up         = rep_q + quad_load_pkg::POS_ONE;
  wire [POS_BITS-1:0] rep_dn         = rep_q - quad_load_pkg::POS_ONE;

  // Single state register; all decoding lives in the named wires above
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= S_TRACK;
    end else begin
      state_q <= state_d;
    end
  end

  // Reloaded on each request edge; a release inside the first delay is not delayed again
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_q <= '0;
    end else if (entering_delay) begin
      dly_q <= load_delay_i;
    end else if (!dly_done) begin
      dly_q <= dly_next;
    end
  end

  // Free-running divider; its one-cycle tick paces every emitted edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
    end else if (edge_tick) begin
      div_q <= edge_div_i;
    end else begin
      div_q <= div_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rep_q <= quad_load_pkg::POS_ZERO;
    end else if (clear_rep) begin
      rep_q <= quad_load_pkg::POS_ZERO;
    end else if (do_up) begin
      rep_q <= rep_up;
    end else if (do_dn) begin
      rep_q <= rep_dn;
    end
  end

  // Phase only moves on a step, and steps are gated off in delay and hold
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q <= quad_load_pkg::PH0;
    end else if (do_up) begin
      phase_q <= phase_up;
    end else if (do_dn) begin
      phase_q <= phase_dn;
    end
  end

  // Tracks are registered off the phase so the pins never glitch
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ta_q <= 1'b0;
      tb_q <= 1'b0;
    end else begin
      ta_q <= track_a_d;
      tb_q <= track_b_d;
    end
  end

  // Flag follows the next state, so it rises with the first delay cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ld_q <= 1'b0;
    end else begin
      ld_q <= loading_d;
    end
  end

  // Tracks frozen from the second loading cycle through delay and hold: they lag the phase a cycle, and phase only moves on do_up/do_dn, gated by state
  assign link.track_a = ta_q;
  assign link.track_b = tb_q;
  assign link.loading = ld_q;

  // Local copies: busy one clock behind the link flag, reported in step with the tracks
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reported_o <= quad_load_pkg::POS_ZERO;
    end else begin
      reported_o <= rep_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= ld_q;
    end
  end
endmodule

// file: rtl/quad_controller_end.sv
// Controller end: quadrature counter with load handshake
module quad_controller_end #(
  parameter int POS_BITS = quad_load_pkg::POS_BITS
) (
  input  wire logic           clk_i,
  input  wire logic           rstn_i,
  input  wire logic           load_start_i,
  output logic [POS_BITS-1:0] count_o,
  output logic                valid_o,
  quad_load_if.controller     link
);
  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_REQ  = 4'h2,
    C_WAIT = 4'h4,
    C_DONE = 4'h8
  } cstate_t;

  cstate_t             st_q, st_d;
  logic [2:0]          a_s_q, b_s_q, l_s_q;
  logic                a_q, b_q, l_q, req_q;
  logic [POS_BITS-1:0] cnt_q;

  // Three-stage syncs; value taken when stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_s_q <= 3'h0;
      b_s_q <= 3'h0;
      l_s_q <= 3'h0;
      a_q   <= 1'b0;
      b_q   <= 1'b0;
      l_q   <= 1'b0;
    end else begin
      a_s_q <= {a_s_q[1:0], link.track_a};
      b_s_q <= {b_s_q[1:0], link.track_b};
      l_s_q <= {l_s_q[1:0], link.loading};
      if (a_s_q[1] == a_s_q[2]) a_q <= a_s_q[2];
      if (b_s_q[1] == b_s_q[2]) b_q <= b_s_q[2];
      if (l_s_q[1] == l_s_q[2]) l_q <= l_s_q[2];
    end
  end

  wire a_new  = (a_s_q[1] == a_s_q[2]) ? a_s_q[2] : a_q;
  wire b_new  = (b_s_q[1] == b_s_q[2]) ? b_s_q[2] : b_q;
  wire a_edge = a_new ^ a_q;
  wire b_edge = b_new ^ b_q;
  // Every edge is one step; climbing order AB is 00, 01, 11, 10, so B leads
  wire up     = (a_edge && (a_new == b_q)) || (b_edge && (b_new != a_q));
  wire dn     = (a_edge && (a_new != b_q)) || (b_edge && (b_new == a_q));

  always_comb begin
    st_d = st_q;
    case (st_q)
      C_IDLE: if (load_start_i) st_d = C_REQ;
      C_REQ:  if (l_q) st_d = C_WAIT;
      C_WAIT: if (!l_q) st_d = C_DONE;
      C_DONE: st_d = C_IDLE;
      default: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q    <= C_IDLE;
      req_q   <= 1'b0;
      cnt_q   <= quad_load_pkg::POS_ZERO;
      valid_o <= 1'b0;
    end else begin
      st_q    <= st_d;
      req_q   <= (st_d == C_REQ);
      if (st_q == C_REQ && l_q) cnt_q <= quad_load_pkg::POS_ZERO;
      else if (up) cnt_q <= cnt_q + quad_load_pkg::POS_ONE;
      else if (dn) cnt_q <= cnt_q - quad_load_pkg::POS_ONE;
      // Count untrusted until replay ends; user must not move axis meanwhile
      valid_o <= (st_d == C_IDLE || st_d == C_DONE) && !l_q && (valid_o || st_q == C_DONE);
    end
  end

  assign link.load_req = req_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) count_o <= quad_load_pkg::POS_ZERO;
    else count_o <= cnt_q;
  end
endmodule

// file: verification/quad_load_assertions.sv
// Concurrent checks on the quadrature load link wires
module quad_load_assertions (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic track_a,
  input wire logic track_b,
  input wire logic load_req,
  input wire logic loading
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [1:0] ab;
  assign ab = {track_a, track_b};
  sequence edge_s;
    $changed(ab);
  endsequence
  sequence replay_s;
    loading && !load_req;
  endsequence
  // Gray steps only: a double change would be read as a lost count
  one_bit_a: assert property (edge_s |-> !($changed(track_a) && $changed(track_b)))
    else $error("both tracks changed at once");
  up_order_a: assert property (replay_s ##0 edge_s |-> ab == {$past(track_b), ~$past(track_a)})
    else $error("replay step not in upward order");
  req_ack_a: assert property ($rose(load_req) |-> ##[1:40] loading)
    else $error("loading flag late after request");
  flag_hold_a: assert property (loading && load_req |=> loading)
    else $error("loading flag fell while request held");
  frozen_a: assert property (load_req && $past(loading) |-> $stable(ab))
    else $error("track edge during held request");
  quiet_gap_a: assert property ($fell(load_req) |=> $stable(ab) [*4])
    else $error("edges started before delay");
  // Bench runs the divider at 3, so edges stand at least four cycles
  spacing_a: assert property (edge_s |=> $stable(ab) [*3])
    else $error("edges closer than divider allows");
  drop_after_a: assert property ($fell(loading) |-> !load_req && !$past(load_req))
    else $error("loading fell with request active");
endmodule

// file: verification/absolute_position_quadrature_loader_tb.sv
// Testbench joining encoder and controller ends over the load link
module absolute_position_quadrature_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [quad_load_pkg::POS_BITS-1:0] pos_t;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic load_start_i = 1'b0;
  pos_t pos_q = 24'h000000;
  logic [quad_load_pkg::DLY_BITS-1:0] dly_q = 16'h0005;
  pos_t reported, count, edges_q;
  logic busy, valid;
  logic [1:0] ab_q;
  logic ld_prev_q = 1'b0;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  pos_t plist [4] = '{24'h000000, 24'h000002, 24'h001001, 24'h001000};
  logic [quad_load_pkg::DLY_BITS-1:0] dlist [4] = '{16'h0005, 16'h0028, 16'h0005, 16'h0028};
  quad_load_if link ();
  quad_encoder_end quad_encoder_end_inst (.clk_i(clk_i), .rstn_i(rstn_i), .position_i(pos_q),
    .load_delay_i(dly_q), .edge_div_i(16'h0003), .reported_o(reported), .busy_o(busy), .link(link));
  quad_controller_end quad_controller_end_inst (.clk_i(clk_i), .rstn_i(rstn_i), .load_start_i(load_start_i),
    .count_o(count), .valid_o(valid), .link(link));
  quad_load_assertions quad_load_assertions_inst (.clk_i(clk_i), .rstn_i(rstn_i), .track_a(link.track_a),
    .track_b(link.track_b), .load_req(link.load_req), .loading(link.loading));
  always #5 clk_i = ~clk_i;
  // Own edge count on the wires, independent of the controller's counter
  always @(posedge clk_i) begin
    ab_q <= {link.track_a, link.track_b};
    ld_prev_q <= link.loading;
    cycles <= cycles + 1;
    // The last replay edge shows with the flag's fall, so the flag is taken a cycle late
    if (load_start_i) edges_q <= '0;
    else if (ld_prev_q && !link.load_req && ab_q != {link.track_a, link.track_b}) edges_q <= edges_q + 1'b1;
    if (cycles == 80000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_pos(input pos_t got, input pos_t exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t position %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic load_pos(input pos_t p, input logic [quad_load_pkg::DLY_BITS-1:0] d);
    int gap;
    logic [1:0] ab0;
    pos_q <= p;
    dly_q <= d;
    // Shaft must be still before loading, else the replay target moves
    @(posedge clk_i iff reported === p);
    repeat (8) @(posedge clk_i);
    chk_pos(count, p);
    load_start_i <= 1'b1;
    @(posedge clk_i);
    load_start_i <= 1'b0;
    @(posedge clk_i iff link.loading === 1'b1);
    repeat (2) @(posedge clk_i);
    chk_bit(busy, 1'b1);
    chk_bit(valid, 1'b0);
    // Cycles since the request went out; no replay edge or flag fall before the delay
    gap = 8;
    ab0 = {link.track_a, link.track_b};
    while (link.loading === 1'b1 && {link.track_a, link.track_b} === ab0) begin
      @(posedge clk_i);
      gap++;
    end
    chk_bit(gap > d, 1'b1);
    @(posedge clk_i iff link.loading === 1'b0);
    @(posedge clk_i iff valid === 1'b1);
    chk_pos(count, p);
    chk_pos(edges_q, p);
    chk_pos(reported, p);
    chk_bit(busy, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    foreach (plist[i]) load_pos(plist[i], dlist[i]);
    end_sim();
  end
endmodule
